// >>> src/vmcfa_pkg.sv
// Package with the field encoding layout, codes and reset values.
package vmcfa_pkg;

  // Bit positions inside a field encoding operand.
  localparam int ENC_ACC_BIT = 0;
  localparam int ENC_IDX_LSB = 1;
  localparam int ENC_IDX_MSB = 9;
  localparam int ENC_TYPE_LSB = 10;
  localparam int ENC_TYPE_MSB = 11;
  localparam int ENC_RSV_BIT = 12;
  localparam int ENC_WID_LSB = 13;
  localparam int ENC_WID_MSB = 14;
  localparam int ENC_RSV_HI_LSB = 15;
  localparam int ENC_RSV_HI_MSB = 31;
  localparam int ENC_UPPER_LSB = 32;

  // Field type codes.
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_READ_ONLY = 2'h1;
  localparam logic [1:0] TYPE_GUEST = 2'h2;
  localparam logic [1:0] TYPE_HOST = 2'h3;

  // Field width codes.
  localparam logic [1:0] WID_16 = 2'h0;
  localparam logic [1:0] WID_64 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;
  localparam logic [1:0] WID_NAT = 2'h3;

  // Access type values of encoding bit 0.
  localparam logic ACC_FULL = 1'b0;
  localparam logic ACC_HIGH = 1'b1;

  // Set when the device supports the 64-bit architecture extension.
  localparam logic SUPPORT_64 = 1'b1;

  // Number of index bits that address the field storage.
  localparam int MEM_IDX_W = 2;
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;

  // Index of the instruction-error field (read-only, 32-bit).
  localparam logic [8:0] ERR_FIELD_IDX = 9'h000;
  // Indices of the saved I/O fields (read-only, natural width).
  localparam logic [1:0] IO_CNT_IDX = 2'h0;
  localparam logic [1:0] IO_SRC_IDX = 2'h1;
  localparam logic [1:0] IO_DST_IDX = 2'h2;
  localparam logic [1:0] IO_IP_IDX = 2'h3;

  // Error code recorded for an access to an unsupported field.
  localparam logic [31:0] ERR_CODE_BAD_FIELD = 32'h0000_0001;

  // Values after reset.
  localparam logic [31:0] ERR_RESET = 32'h0000_0000;
  localparam logic [63:0] IO_RESET = 64'h0000_0000_0000_0000;

  // Common masks.
  localparam logic [63:0] MASK_16 = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] MASK_32 = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] MASK_HI = 64'hFFFF_FFFF_0000_0000;
  localparam logic [63:0] MASK_ALL = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] ZERO_64 = 64'h0000_0000_0000_0000;

  // All state of the access logic except the field storage and its read register.
  typedef struct packed {
    logic fail;
    logic active;
    logic writeback;
    logic [31:0] instr_err;
    logic [63:0] io_count;
    logic [63:0] io_src;
    logic [63:0] io_dst;
    logic [63:0] io_ip;
  } vmcfa_state_type;

endpackage

// >>> src/vmcfa_mem.sv
// Field storage memory with masked write and a registered read port.
module vmcfa_mem
  import vmcfa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [MEM_AW-1:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [63:0] wmask_i,
  input wire logic [63:0] wdata_i,
  input wire logic rd_en_i,
  input wire logic rd_hi_i,
  input wire logic [63:0] rd_mask_i,
  input wire logic byp_en_i,
  input wire logic [63:0] byp_data_i,
  output logic [63:0] rd_data_o
);

  // Storage words; software initialises them before use.
  logic [63:0] mem_reg [MEM_DEPTH];
  // Read data register, valid for one cycle after a read.
  logic [63:0] rd_data_reg;
  logic [63:0] rd_data_next;
  // Word under the address, shifted down for high access.
  logic [63:0] word_sel;

  // Read data are formatted before they are registered.
  always_comb begin
    word_sel = rd_hi_i ? {32'h0000_0000, mem_reg[addr_i][63:32]}
                       : mem_reg[addr_i];
    rd_data_next = ZERO_64;
    if (rd_en_i) begin
      rd_data_next = byp_en_i ? byp_data_i : (word_sel & rd_mask_i);
    end
  end

  // Masked write: only bits with a set mask change.
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && wr_en_i) begin
      mem_reg[addr_i] <= (mem_reg[addr_i] & ~wmask_i) | (wdata_i & wmask_i);
    end
  end

  // The read register clears so data stand only in the answer cycle.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= ZERO_64;
    end else if (clk_en_i) begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule

// >>> src/vmcfa_top.sv
// Access logic for the fields of the vm_control_structure.
//
// Contract
// - Fields are named by a 32-bit encoding.
// - In 64-bit mode upper operand bits fail.
// - Bit 0 selects full or high access.
// - High access only for 64-bit width code.
// - Bits 9:1 index fields of one kind.
// - Bits 11:10 give the field type.
// - Bits 12 and 31:15 must be zero.
// - Bits 14:13 give the field width.
// - Natural width is 64 bits here.
// - Full access covers the whole field.
// - High access covers upper 32 bits only.
// - Error and exit fields are read-only type.
// - Error field kept, untouched by guest exits.
// - Error field records instruction errors.
// - Saved I/O registers filled on I/O SYSTEM_MANAGEMENT_INTERRUPT exits.
// - Saved pointer addresses the I/O instruction.
// - Clear deactivates and writes data back.
// - 16-bit reads zero the upper destination.
// - High reads return upper half in low bits.
// - Full 64-bit write outside 64-bit clears top.
module vmcfa_top
  import vmcfa_pkg::*;
(
  // Clock, synchronous reset and the freezing clock enable.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Field read and write port of the supervisor software.
  input wire logic mode64_i,
  input wire logic [63:0] fld_addr_i,
  input wire logic [63:0] fld_wdata_i,
  input wire logic fld_wr_i,
  input wire logic fld_rd_i,
  output logic [63:0] fld_rdata_o,
  output logic fld_fail_o,
  // Activation and clear of the structure on this processor.
  input wire logic load_current_i,
  input wire logic clear_i,
  output logic active_o,
  output logic writeback_o,
  // Updates of the hardware-kept instruction-error and saved I/O fields.
  input wire logic instr_err_valid_i,
  input wire logic [31:0] instr_err_code_i,
  input wire logic guest_exit_i,
  input wire logic io_smi_exit_i,
  // Register values from before the interrupted I/O instruction.
  input wire logic [63:0] io_count_i,
  input wire logic [63:0] io_src_i,
  input wire logic [63:0] io_dst_i,
  input wire logic [63:0] io_ip_i
);

  // Registered state and its next value.
  vmcfa_state_type state_reg;
  vmcfa_state_type state_next;

  // Decoded fields of the current encoding.
  logic enc_acc;
  logic [8:0] enc_idx;
  logic [1:0] enc_type;
  logic [1:0] enc_wid;
  // Access request of this cycle.
  logic access;
  // Encoding is well formed.
  logic enc_ok;
  // Encoding names a stored, hardware-kept or saved I/O field.
  logic hit_mem;
  logic hit_err;
  logic hit_io;
  // Access fails.
  logic acc_fail;
  // Memory port controls.
  logic [MEM_AW-1:0] mem_addr;
  logic mem_wr;
  logic [63:0] mem_wmask;
  logic [63:0] mem_wdata;
  logic mem_rd_hi;
  logic [63:0] mem_rd_mask;
  logic mem_byp;
  logic [63:0] mem_byp_data;
  // Saved I/O field picked by the index.
  logic [63:0] io_sel;

  // True when every reserved or out-of-range operand bit is clear and a high access names a 64-bit field.
  function automatic logic enc_well_formed(input logic [63:0] enc,
                                           input logic m64);
    logic bad;
    // Bit 12 and bits 31:15 are reserved in every encoding.
    bad = enc[ENC_RSV_BIT] | (|enc[ENC_RSV_HI_MSB:ENC_RSV_HI_LSB]);
    // The upper operand half only counts in 64-bit mode.
    if (m64) begin
      bad = bad | (|enc[63:ENC_UPPER_LSB]);
    end
    // High access exists for 64-bit fields alone.
    if (enc[ENC_ACC_BIT] == ACC_HIGH &&
        enc[ENC_WID_MSB:ENC_WID_LSB] != WID_64) begin
      bad = 1'b1;
    end
    return !bad;
  endfunction

  // Bits of a field that a full access reaches in the current mode.
  function automatic logic [63:0] full_mask(input logic [1:0] wid,
                                            input logic m64);
    logic [63:0] m;
    m = MASK_32;
    case (wid)
      WID_16: begin
        // Sixteen-bit fields keep bits 15:0 only.
        m = MASK_16;
      end
      WID_32: begin
        // Thirty-two-bit fields keep bits 31:0.
        m = MASK_32;
      end
      WID_64: begin
        // Outside 64-bit mode only the low half is reached.
        m = m64 ? MASK_ALL : MASK_32;
      end
      WID_NAT: begin
        // Natural width follows the architecture support and mode.
        m = (SUPPORT_64 && m64) ? MASK_ALL : MASK_32;
      end
      default: begin
        // Unreachable: the two-bit width code is fully decoded.
        m = MASK_32;
      end
    endcase
    return m;
  endfunction

  // Bits that a natural-width field holds on this device.
  function automatic logic [63:0] nat_mask();
    return SUPPORT_64 ? MASK_ALL : MASK_32;
  endfunction

  // Field encoding decode.
  always_comb begin
    // Access type: full or high half.
    enc_acc = fld_addr_i[ENC_ACC_BIT];
    // Index among fields of one width and type.
    enc_idx = fld_addr_i[ENC_IDX_MSB:ENC_IDX_LSB];
    // Field type: control, read-only, guest or host.
    enc_type = fld_addr_i[ENC_TYPE_MSB:ENC_TYPE_LSB];
    // Field width code.
    enc_wid = fld_addr_i[ENC_WID_MSB:ENC_WID_LSB];
  end

  // Field classification and the memory port controls.
  always_comb begin
    // Either strobe makes this cycle an access.
    access = fld_rd_i | fld_wr_i;
    enc_ok = enc_well_formed(fld_addr_i, mode64_i);
    // Stored fields: control, guest and host types, small index.
    hit_mem = (enc_type != TYPE_READ_ONLY) &&
              (enc_idx[8:MEM_IDX_W] == 7'h00);
    // Hardware-kept read-only fields.
    hit_err = (enc_type == TYPE_READ_ONLY) && (enc_wid == WID_32) &&
              (enc_idx == ERR_FIELD_IDX);
    hit_io = (enc_type == TYPE_READ_ONLY) && (enc_wid == WID_NAT) &&
             (enc_idx[8:MEM_IDX_W] == 7'h00);
    // Read-only fields refuse writes; unknown fields refuse all.
    acc_fail = !state_reg.active || !enc_ok ||
               !(hit_mem || ((hit_err || hit_io) && !fld_wr_i));
    case (enc_idx[MEM_IDX_W-1:0])
      IO_CNT_IDX: begin
        // Saved count register.
        io_sel = state_reg.io_count;
      end
      IO_SRC_IDX: begin
        // Saved source index register.
        io_sel = state_reg.io_src;
      end
      IO_DST_IDX: begin
        // Saved destination index register.
        io_sel = state_reg.io_dst;
      end
      IO_IP_IDX: begin
        // Saved pointer of the I/O instruction itself.
        io_sel = state_reg.io_ip;
      end
      default: begin
        // Unreachable: the two index bits are fully decoded.
        io_sel = ZERO_64;
      end
    endcase
    // Storage word picked by width, type and the low index bits.
    mem_addr = {enc_wid, enc_type, enc_idx[MEM_IDX_W-1:0]};
    // Only an accepted write may change the storage.
    mem_wr = fld_wr_i && !acc_fail;
    if (enc_acc == ACC_HIGH) begin
      // Source bits 31:0 go to field bits 63:32 only.
      mem_wmask = MASK_HI;
      mem_wdata = {fld_wdata_i[31:0], 32'h0000_0000};
      mem_rd_mask = MASK_32;
    end else begin
      // Whole field written; bits past the access width are cleared.
      mem_wmask = MASK_ALL;
      mem_wdata = fld_wdata_i & full_mask(enc_wid, mode64_i);
      mem_rd_mask = full_mask(enc_wid, mode64_i);
    end
    // A high read shifts the upper half down into bits 31:0.
    mem_rd_hi = (enc_acc == ACC_HIGH);
    // A failed read returns zero; read-only fields bypass the memory.
    mem_byp = acc_fail || hit_err || hit_io;
    if (acc_fail) begin
      // A refused access answers with zero.
      mem_byp_data = ZERO_64;
    end else if (hit_err) begin
      // The error field lives in the state register.
      mem_byp_data = {32'h0000_0000, state_reg.instr_err};
    end else begin
      // A saved I/O field, cut to the width of the current mode.
      mem_byp_data = io_sel & full_mask(WID_NAT, mode64_i);
    end
  end

  // Next state of status, activation and hardware-kept fields.
  always_comb begin
    state_next = state_reg;
    // Status pulses last one cycle unless raised again.
    state_next.fail = access && acc_fail;
    state_next.writeback = 1'b0;
    // Making the structure current.
    if (load_current_i) begin
      state_next.active = 1'b1;
    end
    // A clear deactivates and signals the write back; it wins over a
    // load in the same cycle, so software must order the two.
    if (clear_i) begin
      state_next.active = 1'b0;
      state_next.writeback = 1'b1;
    end
    // A well-formed access to an unknown field is a non-faulting
    // failure and is recorded; a malformed one faults instead.
    if (access && state_reg.active && enc_ok && acc_fail) begin
      state_next.instr_err = ERR_CODE_BAD_FIELD;
    end
    // Errors of other virtualization instructions; guest exits never
    // touch this field.
    if (instr_err_valid_i) begin
      state_next.instr_err = instr_err_code_i;
    end
    // Saved I/O registers hold the values from before the instruction.
    if (guest_exit_i && io_smi_exit_i) begin
      state_next.io_count = io_count_i & nat_mask();
      state_next.io_src = io_src_i & nat_mask();
      state_next.io_dst = io_dst_i & nat_mask();
      state_next.io_ip = io_ip_i & nat_mask();
    end
  end

  // State register; the clock enable freezes everything but the synchronous reset.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      // Status flags start cleared and the structure inactive.
      state_reg.fail <= 1'b0;
      state_reg.active <= 1'b0;
      state_reg.writeback <= 1'b0;
      // Hardware-kept fields start at their reset values.
      state_reg.instr_err <= ERR_RESET;
      state_reg.io_count <= IO_RESET;
      state_reg.io_src <= IO_RESET;
      state_reg.io_dst <= IO_RESET;
      state_reg.io_ip <= IO_RESET;
    end else if (clk_en_i) begin
      // State advances only while the clock enable is high.
      state_reg <= state_next;
    end
  end

  // Field storage with the formatted, registered read port.
  vmcfa_mem u_mem (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .addr_i(mem_addr),
    .wr_en_i(mem_wr),
    .wmask_i(mem_wmask),
    .wdata_i(mem_wdata),
    // Only a read loads the answer register with data.
    .rd_en_i(fld_rd_i),
    .rd_hi_i(mem_rd_hi),
    .rd_mask_i(mem_rd_mask),
    // Refused and read-only reads take the bypass path.
    .byp_en_i(mem_byp),
    .byp_data_i(mem_byp_data),
    .rd_data_o(fld_rdata_o)
  );

  // Outputs straight from the state register.
  // Failure pulse of the access taken one cycle earlier.
  assign fld_fail_o = state_reg.fail;
  // Structure is current on this processor.
  assign active_o = state_reg.active;
  // Write-back request pulse after a clear.
  assign writeback_o = state_reg.writeback;

endmodule

// >>> test/vmcfa_assertions.sv
// Checker of the field access port, activation and clear behaviour of vmcfa_top.
module vmcfa_assertions
  import vmcfa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic mode64_i,
  input wire logic [63:0] fld_addr_i,
  input wire logic fld_wr_i,
  input wire logic fld_rd_i,
  input wire logic [63:0] fld_rdata_o,
  input wire logic fld_fail_o,
  input wire logic load_current_i,
  input wire logic clear_i,
  input wire logic active_o,
  input wire logic writeback_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc; // An access is taken on this edge.
  logic rd; // A read is taken on this edge.
  assign acc = clk_en_i && (fld_rd_i || fld_wr_i);
  assign rd = clk_en_i && fld_rd_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_upper_bits_fail: assert property (
    acc && mode64_i && |fld_addr_i[63:32] |=> fld_fail_o)
    else $error("upper operand bits accepted");
  a_reserved_fail: assert property (
    acc && (fld_addr_i[12] || |fld_addr_i[31:15]) |=> fld_fail_o)
    else $error("reserved bits accepted");
  a_high_width_fail: assert property (
    acc && fld_addr_i[0] && fld_addr_i[14:13] != WID_64 |=> fld_fail_o)
    else $error("high access on non 64-bit field");
  a_fail_cause: assert property (
    fld_fail_o |-> $past(acc) && fld_rdata_o == 64'h0)
    else $error("bad fail pulse");
  a_short_read: assert property (
    rd && fld_addr_i[14:13] == WID_16 |=> fld_rdata_o[63:16] == 48'h0)
    else $error("16-bit read");
  a_high_read: assert property (
    rd && fld_addr_i[0] |=> fld_rdata_o[63:32] == 32'h0)
    else $error("high read");
  a_narrow_read: assert property (
    rd && (!mode64_i || fld_addr_i[14:13] == WID_32)
    |=> fld_rdata_o[63:32] == 32'h0)
    else $error("narrow read upper bits");
  a_clear_deact: assert property (
    clk_en_i && clear_i |=> !active_o && writeback_o)
    else $error("clear");
  a_wb_cause: assert property (
    writeback_o |-> $past(clear_i && clk_en_i))
    else $error("write back without clear");
  a_load_active: assert property (
    clk_en_i && load_current_i && !clear_i |=> active_o)
    else $error("load did not activate");
endmodule
bind vmcfa_top vmcfa_assertions u_chk (.core_clk_i, .rst_n_i, .clk_en_i,
  .mode64_i, .fld_addr_i, .fld_wr_i, .fld_rd_i, .fld_rdata_o, .fld_fail_o,
  .load_current_i, .clear_i, .active_o, .writeback_o);

// >>> test/vmcfa_sw.sv
// Model of supervisor software issuing field read and write instructions.
module vmcfa_sw (
  input wire logic core_clk_i,
  input wire logic [63:0] fld_rdata_i,
  input wire logic fld_fail_i,
  output logic [63:0] fld_addr_o,
  output logic [63:0] fld_wdata_o,
  output logic fld_wr_o,
  output logic fld_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fld_addr_o = 64'h0;
    fld_wdata_o = 64'h0;
    fld_wr_o = 1'b0;
    fld_rd_o = 1'b0;
  end
  // Fields are reached only through field instructions.
  // One transfer: strobe for one cycle, answer sampled in the next cycle.
  task automatic xfer(input logic w, input logic [63:0] a, d,
                      output logic [63:0] q, output logic f);
    @(posedge core_clk_i);
    fld_wr_o <= w;
    fld_rd_o <= !w;
    fld_addr_o <= a;
    fld_wdata_o <= d;
    @(posedge core_clk_i);
    fld_wr_o <= 1'b0;
    fld_rd_o <= 1'b0;
    // Released operands are scrambled so stale values never help.
    fld_addr_o <= ~a;
    fld_wdata_o <= ~d;
    #1;
    q = fld_rdata_i;
    f = fld_fail_i;
  endtask
endmodule

// >>> test/vmcfa_test.sv
// Self-checking testbench of the field access logic.
module vmcfa_test;
  import vmcfa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] D = 64'hFEDC_BA98_7654_3210;
  logic core_clk_i, rst_n_i, clk_en_i, mode64_i, fld_wr_i, fld_rd_i;
  logic load_current_i, clear_i, instr_err_valid_i, guest_exit_i;
  logic io_smi_exit_i, fld_fail_o, active_o, writeback_o, f;
  logic [31:0] instr_err_code_i;
  logic [63:0] fld_addr_i, fld_wdata_i, fld_rdata_o, q, a;
  logic [63:0] iov [4];
  logic [63:0] bad [5];
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  vmcfa_top uut (.core_clk_i, .rst_n_i, .clk_en_i, .mode64_i, .fld_addr_i,
    .fld_wdata_i, .fld_wr_i, .fld_rd_i, .fld_rdata_o, .fld_fail_o,
    .load_current_i, .clear_i, .active_o, .writeback_o, .instr_err_valid_i,
    .instr_err_code_i, .guest_exit_i, .io_smi_exit_i, .io_count_i(iov[0]),
    .io_src_i(iov[1]), .io_dst_i(iov[2]), .io_ip_i(iov[3]));
  vmcfa_sw u_sw (.core_clk_i, .fld_rdata_i(fld_rdata_o),
    .fld_fail_i(fld_fail_o), .fld_addr_o(fld_addr_i),
    .fld_wdata_o(fld_wdata_i), .fld_wr_o(fld_wr_i), .fld_rd_o(fld_rd_i));
  function automatic logic [63:0] enc(logic [1:0] wd, tp, logic [8:0] ix,
                                      logic ac);
    return {49'h0, wd, 1'b0, tp, ix, ac};
  endfunction
  task automatic chk(input logic [63:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [63:0] ad, d, input logic ef);
    u_sw.xfer(1'b1, ad, d, q, f);
    chk(f, ef);
  endtask
  task automatic r(input logic [63:0] ad, e, input logic ef);
    u_sw.xfer(1'b0, ad, 64'h0, q, f);
    chk(f, ef);
    chk(q, e);
  endtask
  // One-cycle pulse on {load, clear, error valid, guest exit}.
  task automatic ctl(input logic [3:0] v);
    @(posedge core_clk_i);
    {load_current_i, clear_i, instr_err_valid_i, guest_exit_i} <= v;
    @(posedge core_clk_i);
    {load_current_i, clear_i, instr_err_valid_i, guest_exit_i} <= 4'h0;
    #1;
  endtask
  task automatic results;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {rst_n_i, load_current_i, clear_i, instr_err_valid_i} = 4'h0;
    {guest_exit_i, io_smi_exit_i, instr_err_code_i} = 34'h0;
    clk_en_i = 1'b1;
    mode64_i = 1'b1;
    for (int k = 0; k < 4; k++) iov[k] = {16'(k), 48'h1234_5678_9ABC};
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    r(enc(WID_32, TYPE_CONTROL, 9'h1, 1'b0), 64'h0, 1'b1);
    ctl(4'h8);
    chk(active_o, 1'b1);
    $display("activation test done");
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 4; k++) begin
        if (t != 1) begin
          a = enc(k[1:0], t[1:0], 9'h1, 1'b0);
          w(a, D, 1'b0);
          r(a, D & (k == 0 ? MASK_16 : k == 2 ? MASK_32 : MASK_ALL),
            1'b0);
        end
      end
    end
    w(enc(WID_64, TYPE_CONTROL, 9'h2, 1'b0), ~D, 1'b0);
    r(enc(WID_64, TYPE_CONTROL, 9'h1, 1'b0), D, 1'b0);
    $display("width test done");
    a = enc(WID_64, TYPE_GUEST, 9'h3, 1'b0);
    w(a, D, 1'b0);
    w(a | 64'h1, 64'h1111_2222_3333_4444, 1'b0);
    r(a, {32'h3333_4444, D[31:0]}, 1'b0);
    r(a | 64'h1, 64'h3333_4444, 1'b0);
    @(posedge core_clk_i);
    mode64_i <= 1'b0;
    w(a, D, 1'b0);
    r(a | 64'h1, 64'h0, 1'b0);
    r(a | 64'h1_0000_0000, {32'h0, D[31:0]}, 1'b0);
    @(posedge core_clk_i);
    mode64_i <= 1'b1;
    $display("high access test done");
    bad = '{a | 64'h1000, a | 64'h8000, a | 64'h8000_0000,
            a | 64'h1_0000_0000, enc(WID_NAT, TYPE_HOST, 9'h1, 1'b1)};
    foreach (bad[i]) begin
      w(bad[i], 64'h0, 1'b1);
      r(bad[i], 64'h0, 1'b1);
    end
    r(a, {32'h0, D[31:0]}, 1'b0);
    $display("refusal test done");
    @(posedge core_clk_i);
    instr_err_code_i <= 32'hCAFE_0042;
    ctl(4'h2);
    r(64'h4400, 64'hCAFE_0042, 1'b0);
    ctl(4'h1);
    r(64'h4400, 64'hCAFE_0042, 1'b0);
    w(64'h4400, 64'h5, 1'b1);
    r(64'h4400, 64'(ERR_CODE_BAD_FIELD), 1'b0);
    $display("error field test done");
    @(posedge core_clk_i);
    io_smi_exit_i <= 1'b1;
    ctl(4'h1);
    @(posedge core_clk_i);
    io_smi_exit_i <= 1'b0;
    for (int k = 0; k < 4; k++) iov[k] <= ~iov[k];
    ctl(4'h1);
    for (int k = 0; k < 4; k++) begin
      r(enc(WID_NAT, TYPE_READ_ONLY, 9'(k), 1'b0),
        {16'(k), 48'h1234_5678_9ABC}, 1'b0);
    end
    $display("saved I/O test done");
    // A clear while the clock enable is low must leave all state frozen.
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    ctl(4'h4);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    #1;
    chk(active_o, 1'b1);
    chk(writeback_o, 1'b0);
    $display("clock enable test done");
    // Clear before reuse or power removal.
    ctl(4'h4);
    chk(active_o, 1'b0);
    chk(writeback_o, 1'b1);
    r(a, 64'h0, 1'b1);
    $display("clear test done");
    results();
  end
endmodule
